/* hw/clm_defs.svh */
// Purpose: constants of the computer-link command master
// Assumes: 125 MHz ref_clk, ASCII characters on a byte link
// Notes: timing counts derive from printed times and clock rate
//
// Overview of operation
// - command starts with percent or less-than
// - unit number field follows start code
// - command text sent in upper case
// - check code is XOR, two hex chars
// - two asterisks skip the check code
// - command ends with carriage return
// - frame length limit 118 or 2048
// - master sends first, then turns alternate
// - all frame content is ASCII
// - long data may span several frames; the master instead cuts text at the frame limit and reports ST_FORMAT
`ifndef CLM_DEFS_SVH
`define CLM_DEFS_SVH
`define CLM_CH_PCT 8'h25
`define CLM_CH_LT 8'h3C
`define CLM_CH_CR 8'h0D
`define CLM_CH_STAR 8'h2A
`define CLM_CH_ACK 8'h24
`define CLM_CH_NAK 8'h21
`define CLM_CH_ZERO 8'h30
`define CLM_CH_HEXA 8'h37
`define CLM_UNIT_MIN 7'h01
`define CLM_UNIT_MAX 7'h63
`define CLM_MAX_PCT 12'h076
`define CLM_MAX_LT 12'h800
`define CLM_FRAME_OVH 12'h006
`define CLM_CLK_MHZ 125
`define CLM_RSP_TIMEOUT_US 1000
`define CLM_RSP_TIMEOUT_CYC (`CLM_RSP_TIMEOUT_US * `CLM_CLK_MHZ)
`define CLM_FIFO_DEPTH 16
`define CLM_FIFO_W 9
`endif

/* hw/clm_pkg.sv */
// Purpose: types of the computer-link command master
// Assumes: nothing
// Notes: binary state codes written out
package clm_pkg;
  typedef enum logic [3:0] {
    TX_IDLE = 4'b0000,
    TX_HDR = 4'b0001,
    TX_U1 = 4'b0010,
    TX_U2 = 4'b0011,
    TX_TXT = 4'b0100,
    TX_DRAIN = 4'b0101,
    TX_B1 = 4'b0110,
    TX_B2 = 4'b0111,
    TX_CR = 4'b1000,
    TX_WAIT = 4'b1001,
    TX_DROP = 4'b1010
  } clm_tx_state_type;
  typedef enum logic [2:0] {
    RX_HDR = 3'b000,
    RX_U1 = 3'b001,
    RX_U2 = 3'b010,
    RX_ACK = 3'b011,
    RX_N1 = 3'b100,
    RX_N2 = 3'b101,
    RX_BODY = 3'b110
  } clm_rx_state_type;
  typedef enum logic [2:0] {
    ST_OK = 3'b000,
    ST_NAK = 3'b001,
    ST_BCC = 3'b010,
    ST_TIMEOUT = 3'b011,
    ST_FORMAT = 3'b100,
    ST_BAD_UNIT = 3'b101
  } clm_status_type;
endpackage : clm_pkg

/* hw/clm_fifo_if.sv */
// Purpose: carrier between the master and its text buffer
// Assumes: one clock
// Notes: valid/ready on both sides
interface clm_fifo_if #(parameter int W = 9);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;
  modport buffer_side (input in_valid, in_data, out_ready,
    output in_ready, out_valid, out_data);
  modport user_side (output in_valid, in_data, out_ready,
    input in_ready, out_valid, out_data);
endinterface : clm_fifo_if

/* hw/clm_fifo.sv */
// Purpose: synchronous FIFO for command text
// Assumes: DEPTH is a power of two
// Notes: ready and valid come from flops
module clm_fifo #(
  parameter int W = 9,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // buffer ports
  clm_fifo_if.buffer_side bus
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic [AW:0] cnt_d;
  logic push;
  logic pop;
  logic rdy_q;
  logic vld_q;

  assign push = bus.in_valid && rdy_q;
  assign pop = bus.out_ready && vld_q;
  assign bus.in_ready = rdy_q;
  assign bus.out_valid = vld_q;
  assign bus.out_data = mem_q[rd_q];

  always_comb begin
    cnt_d = cnt_q;
    if (push && !pop) begin
      cnt_d = cnt_q + 1'b1;
    end else if (pop && !push) begin
      cnt_d = cnt_q - 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (push) begin
      mem_q[wr_q] <= bus.in_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      rdy_q <= 1'b0;
      vld_q <= 1'b0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q <= cnt_d;
      // full and empty held in flops so ports never glitch
      rdy_q <= cnt_d != (AW+1)'(DEPTH);
      vld_q <= cnt_d != '0;
    end
  end
endmodule : clm_fifo

/* hw/clm_master.sv */
// Purpose: master that frames commands and checks replies
// Assumes: byte link and user logic on ref_clk
// Notes: one command in flight; a silent device ends in timeout
`include "clm_defs.svh"
module clm_master import clm_pkg::*; #(
  parameter int RSP_TIMEOUT_CYC = `CLM_RSP_TIMEOUT_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // command request
  input wire logic cmd_start,
  input wire logic cmd_long,
  input wire logic [6:0] cmd_unit,
  input wire logic cmd_skip_check,
  output logic cmd_busy,
  // command text stream
  input wire logic txt_valid,
  input wire logic [7:0] txt_data,
  input wire logic txt_last,
  output logic txt_ready,
  // character link
  output logic tx_valid,
  output logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // reply
  output logic rsp_valid,
  output logic [7:0] rsp_data,
  output logic rsp_done,
  output logic [2:0] rsp_status
);
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'hA) ? `CLM_CH_ZERO + {4'h0, n}
                          : `CLM_CH_HEXA + {4'h0, n};
  endfunction : hex_char

  function automatic logic [7:0] to_upper(input logic [7:0] c);
    to_upper = (c >= 8'h61 && c <= 8'h7A) ? c - 8'h20 : c;
  endfunction : to_upper

  function automatic logic is_start(input logic [7:0] c);
    is_start = c == `CLM_CH_PCT || c == `CLM_CH_LT;
  endfunction : is_start

  function automatic logic [11:0] frame_max(input logic lng);
    frame_max = lng ? `CLM_MAX_LT : `CLM_MAX_PCT;
  endfunction : frame_max

  clm_fifo_if #(.W(`CLM_FIFO_W)) fif ();

  clm_fifo #(.W(`CLM_FIFO_W), .DEPTH(`CLM_FIFO_DEPTH)) u_fifo (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .bus(fif.buffer_side)
  );

  clm_tx_state_type tx_st_q;
  clm_rx_state_type rx_st_q;
  logic tx_valid_q;
  logic [7:0] tx_data_q;
  logic busy_q;
  logic long_q;
  logic skip_q;
  logic [7:0] hdr_q;
  logic [7:0] unit_hi_q;
  logic [7:0] unit_lo_q;
  logic [7:0] name0_q;
  logic [7:0] name1_q;
  logic [7:0] tx_bcc_q;
  logic [11:0] tx_cnt_q;
  logic ovf_q;
  logic badu_q;
  logic can_send;
  logic [7:0] txt_ch;
  logic [7:0] rx_xor_q;
  logic [7:0] d1_q;
  logic [7:0] d2_q;
  logic [1:0] held_q;
  logic [11:0] rx_len_q;
  logic nak_q;
  logic rx_fin_q;
  clm_status_type rx_stat_q;
  logic rsp_valid_q;
  logic [7:0] rsp_data_q;
  logic [31:0] tmo_cnt_q;
  logic tmo_q;
  logic done_q;
  clm_status_type stat_q;
  logic armed;
  logic bcc_ok;

  assign can_send = !tx_valid_q || tx_ready;
  assign txt_ch = to_upper(fif.out_data[7:0]);
  assign fif.in_valid = txt_valid;
  assign fif.in_data = {txt_last, txt_data};
  assign fif.out_ready = (tx_st_q == TX_TXT && can_send)
                      || tx_st_q == TX_DRAIN || tx_st_q == TX_DROP;
  assign txt_ready = fif.in_ready;
  assign armed = tx_st_q == TX_WAIT;
  assign bcc_ok = (d1_q == `CLM_CH_STAR && d2_q == `CLM_CH_STAR)
    || (d1_q == hex_char(rx_xor_q[7:4])
        && d2_q == hex_char(rx_xor_q[3:0]));

  // command framing; the check code stops at the last text char
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tx_st_q <= TX_IDLE;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      busy_q <= 1'b0;
      long_q <= 1'b0;
      skip_q <= 1'b0;
      hdr_q <= `CLM_CH_PCT;
      unit_hi_q <= `CLM_CH_ZERO;
      unit_lo_q <= `CLM_CH_ZERO;
      name0_q <= 8'h00;
      name1_q <= 8'h00;
      tx_bcc_q <= 8'h00;
      tx_cnt_q <= 12'h000;
      ovf_q <= 1'b0;
      badu_q <= 1'b0;
    end else begin
      badu_q <= 1'b0;
      if (tx_valid_q && tx_ready) begin
        tx_valid_q <= 1'b0;
      end
      unique case (tx_st_q)
        TX_IDLE: begin
          if (cmd_start) begin
            long_q <= cmd_long;
            skip_q <= cmd_skip_check;
            hdr_q <= cmd_long ? `CLM_CH_LT : `CLM_CH_PCT;
            unit_hi_q <= `CLM_CH_ZERO + 8'(cmd_unit / 7'h0A);
            unit_lo_q <= `CLM_CH_ZERO + 8'(cmd_unit % 7'h0A);
            tx_bcc_q <= 8'h00;
            tx_cnt_q <= 12'h000;
            ovf_q <= 1'b0;
            busy_q <= 1'b1;
            if (cmd_unit < `CLM_UNIT_MIN || cmd_unit > `CLM_UNIT_MAX) begin
              tx_st_q <= TX_DROP;
            end else begin
              tx_st_q <= TX_HDR;
            end
          end
        end
        TX_HDR: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= hdr_q;
            tx_bcc_q <= hdr_q;
            tx_st_q <= TX_U1;
          end
        end
        TX_U1: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= unit_hi_q;
            tx_bcc_q <= tx_bcc_q ^ unit_hi_q;
            tx_st_q <= TX_U2;
          end
        end
        TX_U2: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= unit_lo_q;
            tx_bcc_q <= tx_bcc_q ^ unit_lo_q;
            tx_st_q <= TX_TXT;
          end
        end
        TX_TXT: begin
          if (can_send && fif.out_valid) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= txt_ch;
            tx_bcc_q <= tx_bcc_q ^ txt_ch;
            tx_cnt_q <= tx_cnt_q + 12'h001;
            if (tx_cnt_q == 12'h000) begin
              name0_q <= txt_ch;
            end
            if (tx_cnt_q == 12'h001) begin
              name1_q <= txt_ch;
            end
            if (fif.out_data[8]) begin
              tx_st_q <= TX_B1;
            end else if (tx_cnt_q == frame_max(long_q) - `CLM_FRAME_OVH
                         - 12'h001) begin
              ovf_q <= 1'b1;
              tx_st_q <= TX_DRAIN;
            end
          end
        end
        TX_DRAIN: begin
          if (fif.out_valid && fif.out_data[8]) begin
            tx_st_q <= TX_B1;
          end
        end
        TX_B1: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= skip_q ? `CLM_CH_STAR : hex_char(tx_bcc_q[7:4]);
            tx_st_q <= TX_B2;
          end
        end
        TX_B2: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= skip_q ? `CLM_CH_STAR : hex_char(tx_bcc_q[3:0]);
            tx_st_q <= TX_CR;
          end
        end
        TX_CR: begin
          if (can_send) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= `CLM_CH_CR;
            tx_st_q <= TX_WAIT;
          end
        end
        TX_WAIT: begin
          if (rx_fin_q || tmo_q) begin
            busy_q <= 1'b0;
            tx_st_q <= TX_IDLE;
          end
        end
        TX_DROP: begin
          if (fif.out_valid && fif.out_data[8]) begin
            badu_q <= 1'b1;
            busy_q <= 1'b0;
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  // reply parsing; the last two chars are held back as the check code
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rx_st_q <= RX_HDR;
      rx_xor_q <= 8'h00;
      d1_q <= 8'h00;
      d2_q <= 8'h00;
      held_q <= 2'b00;
      rx_len_q <= 12'h000;
      nak_q <= 1'b0;
      rx_fin_q <= 1'b0;
      rx_stat_q <= ST_OK;
      rsp_valid_q <= 1'b0;
      rsp_data_q <= 8'h00;
    end else begin
      rx_fin_q <= 1'b0;
      rsp_valid_q <= 1'b0;
      if (!armed) begin
        rx_st_q <= RX_HDR;
      end else if (rx_valid && is_start(rx_data)) begin
        rx_st_q <= (rx_data == hdr_q) ? RX_U1 : RX_HDR;
        rx_xor_q <= rx_data;
        rx_len_q <= 12'h001;
      end else if (rx_valid && rx_st_q != RX_HDR) begin
        // count characters, not cycles; a slow link must not cut frames
        rx_len_q <= rx_len_q + 12'h001;
        rx_xor_q <= rx_xor_q ^ rx_data;
        if (rx_len_q == frame_max(long_q)) begin
          rx_st_q <= RX_HDR;
        end else begin
          unique case (rx_st_q)
            RX_U1: rx_st_q <= (rx_data == unit_hi_q) ? RX_U2 : RX_HDR;
            RX_U2: rx_st_q <= (rx_data == unit_lo_q) ? RX_ACK : RX_HDR;
            RX_ACK: begin
              nak_q <= rx_data == `CLM_CH_NAK;
              rx_st_q <= (rx_data == `CLM_CH_ACK
                          || rx_data == `CLM_CH_NAK) ? RX_N1 : RX_HDR;
            end
            RX_N1: rx_st_q <= (rx_data == name0_q) ? RX_N2 : RX_HDR;
            RX_N2: begin
              rx_st_q <= (rx_data == name1_q) ? RX_BODY : RX_HDR;
              held_q <= 2'b00;
            end
            RX_BODY: begin
              if (rx_data == `CLM_CH_CR) begin
                rx_xor_q <= rx_xor_q;
                rx_fin_q <= 1'b1;
                rx_st_q <= RX_HDR;
                if (held_q != 2'b10) begin
                  rx_stat_q <= ST_FORMAT;
                end else if (!bcc_ok) begin
                  rx_stat_q <= ST_BCC;
                end else if (nak_q) begin
                  rx_stat_q <= ST_NAK;
                end else begin
                  rx_stat_q <= ovf_q ? ST_FORMAT : ST_OK;
                end
              end else if (held_q == 2'b10) begin
                rsp_valid_q <= 1'b1;
                rsp_data_q <= d1_q;
                rx_xor_q <= rx_xor_q ^ d1_q;
                d1_q <= d2_q;
                d2_q <= rx_data;
              end else begin
                rx_xor_q <= rx_xor_q;
                held_q <= held_q + 2'b01;
                d1_q <= (held_q == 2'b00) ? rx_data : d1_q;
                d2_q <= rx_data;
              end
            end
            default: rx_st_q <= RX_HDR;
          endcase
        end
      end
    end
  end

  // a lost reply must not hang the master
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      tmo_cnt_q <= 32'h0000_0000;
      tmo_q <= 1'b0;
    end else begin
      tmo_q <= armed && !rx_fin_q && !tmo_q
            && tmo_cnt_q == 32'(RSP_TIMEOUT_CYC - 1);
      tmo_cnt_q <= armed ? tmo_cnt_q + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      done_q <= 1'b0;
      stat_q <= ST_OK;
    end else begin
      done_q <= (armed && (rx_fin_q || tmo_q)) || badu_q;
      if (badu_q) begin
        stat_q <= ST_BAD_UNIT;
      end else if (rx_fin_q) begin
        stat_q <= rx_stat_q;
      end else if (tmo_q) begin
        stat_q <= ST_TIMEOUT;
      end
    end
  end

  assign cmd_busy = busy_q;
  assign tx_valid = tx_valid_q;
  assign tx_data = tx_data_q;
  assign rsp_valid = rsp_valid_q;
  assign rsp_data = rsp_data_q;
  assign rsp_done = done_q;
  assign rsp_status = stat_q;
endmodule : clm_master

/* testbench/clm_dev_model.sv */
// Purpose: device end of the computer link, answers commands
// Assumes: at most one character per cycle in each direction
// Notes: fault 1 refuses, 2 spoils the check code, 3 sends a stray start
module clm_dev_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // character link
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  // scenario controls
  input wire logic [6:0] own_unit,
  input wire logic [1:0] fault,
  input wire logic slow,
  input wire logic [7:0] dscan
);
  logic [7:0] cmd[$];
  logic got_cr = 1'b0;
  function automatic logic [7:0] hexc(input logic [3:0] d);
    return d < 4'hA ? 8'h30 + 8'(d) : 8'h37 + 8'(d);
  endfunction : hexc
  function automatic logic [7:0] dig(input logic [6:0] u, input logic hi);
    return 8'h30 + 8'(hi ? u / 7'h0A : u % 7'h0A);
  endfunction : dig
  initial tx_ready = 1'b0;
  // stalls every other cycle when slow
  always @(negedge ref_clk) tx_ready <= !slow || !tx_ready;
  always @(posedge ref_clk) begin
    if (rstn && tx_valid && tx_ready) begin
      if (tx_data == 8'h25 || tx_data == 8'h3C) cmd.delete();
      cmd.push_back(tx_data);
      got_cr <= (tx_data == 8'h0D);
    end
  end
  task automatic answer();
    logic [7:0] r[$];
    logic [7:0] x;
    int lim;
    x = 8'h00;
    lim = cmd[0] == 8'h25 ? 118 : 2048;
    if (cmd.size() < 8 || cmd.size() > lim) return;
    for (int k = 0; k < cmd.size() - 3; k++) x ^= cmd[k];
    if (cmd[1] != dig(own_unit, 1) || cmd[2] != dig(own_unit, 0)) return;
    if ({cmd[$-2], cmd[$-1]} != 16'h2A2A &&
        (cmd[$-2] != hexc(x[7:4]) || cmd[$-1] != hexc(x[3:0]))) return;
    r = {cmd[0], dig(own_unit, 1), dig(own_unit, 0)};
    r.push_back(fault == 2'h1 ? 8'h21 : 8'h24);
    r = {r, cmd[3], cmd[4]};
    if (fault == 2'h1) r = {r, 8'h34, 8'h32};
    else r = {r, cmd[5:$-3]};
    // echo cut so the reply itself stays within the frame limit
    while (r.size() > lim - 3) r.pop_back();
    x = 8'h00;
    foreach (r[k]) x ^= r[k];
    if (fault == 2'h2) x = ~x;
    r = {r, hexc(x[7:4]), hexc(x[3:0]), 8'h0D};
    if (fault == 2'h3) r = {cmd[0], 8'h30, r};
    repeat (dscan + 2) @(negedge ref_clk);
    foreach (r[k]) begin
      rx_valid = 1'b1;
      rx_data = r[k];
      @(negedge ref_clk);
      rx_valid = 1'b0;
      // no stale value between characters
      rx_data = ~r[k];
      if (slow) @(negedge ref_clk);
    end
  endtask : answer
  // speaks only after a whole command
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    forever begin
      @(negedge ref_clk);
      if (got_cr) begin
        got_cr = 1'b0;
        answer();
      end
    end
  end
endmodule : clm_dev_model

/* testbench/clm_master_asserts.sv */
// Purpose: port checks of the command master
// Assumes: one clock domain, reset active low
// Notes: timeout window allows a few cycles of slack
module clm_master_asserts #(
  parameter int RSP_TIMEOUT_CYC = 125000
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // command request
  input wire logic cmd_start,
  input wire logic cmd_long,
  input wire logic [6:0] cmd_unit,
  input wire logic cmd_skip_check,
  input wire logic cmd_busy,
  // command text stream
  input wire logic txt_valid,
  input wire logic [7:0] txt_data,
  input wire logic txt_last,
  input wire logic txt_ready,
  // character link
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_ready,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  // reply
  input wire logic rsp_valid,
  input wire logic [7:0] rsp_data,
  input wire logic rsp_done,
  input wire logic [2:0] rsp_status
);
  int wait_cnt_q;
  logic bad_start;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  assign bad_start = cmd_start && !cmd_busy &&
    (cmd_unit == 7'h00 || cmd_unit > 7'h63);
  // quiet busy cycles since the last character left
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      wait_cnt_q <= 0;
    end else if (tx_valid || !cmd_busy) begin
      wait_cnt_q <= 0;
    end else begin
      wait_cnt_q <= wait_cnt_q + 1;
    end
  end
  a_start_busy: assert property (cmd_start && !cmd_busy |=> cmd_busy)
    else $error("busy not raised after start");
  a_hdr_code: assert property (cmd_start && !cmd_busy && !bad_start |-> ##2
    tx_valid && tx_data == ($past(cmd_long, 2) ? 8'h3C : 8'h25))
    else $error("wrong or late start code");
  a_bad_unit_quiet: assert property (bad_start |=> !tx_valid [*8])
    else $error("frame sent to an illegal unit");
  a_bad_unit_status: assert property (bad_start |->
    ##[1:200] (rsp_done && rsp_status == 3'h5))
    else $error("illegal unit not reported");
  a_tx_holds: assert property (tx_valid && !tx_ready |=>
    tx_valid && $stable(tx_data))
    else $error("link character dropped or changed");
  a_idle_silent: assert property (!cmd_busy |-> !tx_valid && !rsp_valid)
    else $error("activity while idle");
  a_done_single: assert property (rsp_done |=> !rsp_done)
    else $error("done longer than one cycle");
  a_cr_ends_frame: assert property (tx_valid && tx_ready &&
    tx_data == 8'h0D |=> !tx_valid [*2])
    else $error("characters after terminator");
  a_timeout_span: assert property (rsp_done && rsp_status == 3'h3 |->
    wait_cnt_q >= RSP_TIMEOUT_CYC - 4 && wait_cnt_q <= RSP_TIMEOUT_CYC + 8)
    else $error("timeout at wrong time");
endmodule : clm_master_asserts
bind clm_master clm_master_asserts #(.RSP_TIMEOUT_CYC(RSP_TIMEOUT_CYC))
  clm_master_asserts_i (.ref_clk(ref_clk), .rstn(rstn),
  .cmd_start(cmd_start), .cmd_long(cmd_long), .cmd_unit(cmd_unit),
  .cmd_skip_check(cmd_skip_check), .cmd_busy(cmd_busy),
  .txt_valid(txt_valid), .txt_data(txt_data), .txt_last(txt_last),
  .txt_ready(txt_ready), .tx_valid(tx_valid), .tx_data(tx_data),
  .tx_ready(tx_ready), .rx_valid(rx_valid), .rx_data(rx_data),
  .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_done(rsp_done),
  .rsp_status(rsp_status));

/* testbench/testbench.sv */
// Purpose: self-checking bench of the command master
// Assumes: device model echoes command text as reply body
// Notes: short timeout keeps the silent-device case brief
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int TMO = 400;
  logic ref_clk = 1'b0, rstn = 1'b0, slow = 1'b0;
  logic cmd_start = 1'b0, cmd_long = 1'b0, cmd_skip_check = 1'b0;
  logic [6:0] cmd_unit = 7'h01, own_unit = 7'h01;
  logic txt_valid = 1'b0, txt_last = 1'b0, tx_ready, tx_valid, rx_valid;
  logic [7:0] txt_data = 8'h00, tx_data, rx_data, rsp_data, dscan = 8'h00;
  logic cmd_busy, txt_ready, rsp_valid, rsp_done;
  logic [2:0] rsp_status;
  logic [1:0] fault = 2'h0;
  logic [31:0] lfsr = 32'hE7C5;
  logic [7:0] got_tx[$], got_rsp[$];
  int mismatches = 0, samples_checked = 0;
  always #4 ref_clk = ~ref_clk;
  clm_master #(.RSP_TIMEOUT_CYC(TMO)) clm_master_i (.ref_clk(ref_clk),
    .rstn(rstn), .cmd_start(cmd_start), .cmd_long(cmd_long),
    .cmd_unit(cmd_unit), .cmd_skip_check(cmd_skip_check),
    .cmd_busy(cmd_busy), .txt_valid(txt_valid), .txt_data(txt_data),
    .txt_last(txt_last), .txt_ready(txt_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
    .rx_data(rx_data), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
    .rsp_done(rsp_done), .rsp_status(rsp_status));
  clm_dev_model clm_dev_i (.ref_clk(ref_clk), .rstn(rstn),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .own_unit(own_unit),
    .fault(fault), .slow(slow), .dscan(dscan));
  always @(posedge ref_clk) begin
    if (tx_valid === 1'b1 && tx_ready) got_tx.push_back(tx_data);
    if (rsp_valid === 1'b1) got_rsp.push_back(rsp_data);
  end
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd
  task automatic check(input string what, input logic [31:0] e,
      input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %0h seen %0h", what, e, g);
    end
  endtask : check
  task automatic cmp_q(input string what, input logic [7:0] e[$],
      input logic [7:0] g[$]);
    check({what, " count"}, e.size(), g.size());
    foreach (e[k]) if (k < g.size()) check(what, e[k], g[k]);
  endtask : cmp_q
  task automatic feed(input logic [7:0] t[$]);
    foreach (t[k]) begin
      txt_valid <= 1'b1;
      txt_data <= t[k];
      txt_last <= (k == t.size() - 1);
      // ready stands from the last rising edge up to the next one
      while (txt_ready !== 1'b1) @(negedge ref_clk);
      @(negedge ref_clk);
    end
    txt_valid <= 1'b0;
    txt_last <= 1'b0;
  endtask : feed
  task automatic run_cmd(input logic lng, input logic [6:0] unit,
      input logic skip, input int n);
    logic [7:0] t[$], et[$], er[$];
    logic [7:0] x;
    logic [2:0] st;
    int lim, w;
    lim = (lng ? 2048 : 118) - 6;
    t = {8'h52, 8'h44};
    // mixed case; the master must raise it
    while (t.size() < n)
      t.push_back(8'h41 + 8'(rnd() % 26) + (rnd() % 2 ? 8'h20 : 8'h00));
    et = {lng ? 8'h3C : 8'h25, clm_dev_i.dig(unit, 1), clm_dev_i.dig(unit, 0)};
    foreach (t[k]) if (k < lim) et.push_back(t[k] & 8'hDF);
    x = 8'h00;
    foreach (et[k]) x ^= et[k];
    if (skip) et = {et, 8'h2A, 8'h2A, 8'h0D};
    else et = {et, clm_dev_i.hexc(x[7:4]), clm_dev_i.hexc(x[3:0]), 8'h0D};
    er = et[5:$-3];
    while (er.size() > lim - 3) er.pop_back();
    st = (fault == 2'h1 || fault == 2'h2) ? {1'b0, fault} : 3'h0;
    if (fault == 2'h1) er = {8'h34, 8'h32};
    if (n > lim) st = 3'h4;
    if (unit != own_unit) st = 3'h3;
    if (unit == 7'h00 || unit > 7'h63) st = 3'h5;
    if (st == 3'h3 || st == 3'h5) er.delete();
    if (st == 3'h5) et.delete();
    got_tx.delete();
    got_rsp.delete();
    fork
      feed(t);
      begin
        // long text fills the buffer before the start
        repeat (n > 16 ? 24 : 1) @(negedge ref_clk);
        if (n > 16) check("txt_ready when full", 0, txt_ready);
        cmd_start <= 1'b1;
        cmd_long <= lng;
        cmd_unit <= unit;
        cmd_skip_check <= skip;
        @(negedge ref_clk);
        cmd_start <= 1'b0;
        w = 0;
        while (rsp_done !== 1'b1 && w < 4000) begin
          @(negedge ref_clk);
          w++;
        end
        check("rsp_done", 1, rsp_done);
      end
    join
    check("status", st, rsp_status);
    cmp_q("link char", et, got_tx);
    cmp_q("reply char", er, got_rsp);
    repeat (2) @(negedge ref_clk);
  endtask : run_cmd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
    check("txt_ready after reset", 1, txt_ready);
    run_cmd(0, 7'h01, 0, 6);
    own_unit = 7'h63;
    slow = 1'b1;
    dscan = 8'h1E;
    run_cmd(1, 7'h63, 1, 20);
    slow = 1'b0;
    dscan = 8'h00;
    own_unit = 7'h01;
    for (int f = 1; f < 4; f++) begin
      fault = f[1:0];
      run_cmd(0, 7'h01, 0, 4);
    end
    fault = 2'h0;
    run_cmd(0, 7'h07, 0, 3);
    run_cmd(0, 7'h00, 0, 3);
    run_cmd(1, 7'h64, 0, 3);
    run_cmd(0, 7'h01, 0, 115);
    repeat (4) begin
      own_unit = 7'(rnd() % 99 + 1);
      slow = 1'(rnd());
      run_cmd(1'(rnd()), own_unit, 1'(rnd()), int'(rnd() % 10) + 2);
    end
    print_verdict();
  end
  initial begin
    #200000;
    mismatches++;
    print_verdict();
  end
endmodule : testbench
